/* File: bench/autocycle_and_channel_select_config_tb.sv */
// Purpose: Self-checking bench for the autocycle and channel mask bank
// Assumes: Default timer length, so every period is measured in full
// Notes: Whole run stays near 34000 cycles; watchdog allows 60000
`timescale 1ns/10ps
`default_nettype none

module autocycle_and_channel_select_config_tb;
    localparam logic [7:0] SEQ_ADDR = 8'h88;
    localparam logic [7:0] AC_ADDR = 8'h8C;
    localparam logic [7:0] MASK_ADDR = 8'h90;
    localparam logic [7:0] BAD_ADDR = 8'h40;
    localparam logic [1:0] OKAY = 2'h0;
    localparam logic [1:0] SLVERR = 2'h2;
    logic sysClk, resetN, awValid, awReady, wValid, wReady, bValid, bReady;
    logic arValid, arReady, rValid, rReady, convertStart, acEnable, seqOn;
    logic [7:0] awAddr, arAddr;
    logic [31:0] wData, rData;
    logic [3:0] wStrb;
    logic [1:0] bResp, rResp;
    logic [2:0] periodSel;
    logic [15:0] chanInc;
    int errCount, nCompared, gap;
    int usTab[8] = '{10, 20, 40, 80, 100, 200, 400, 800};

    autocycle_and_channel_select_config dut_u (
        .sys_clk(sysClk), .reset_n(resetN),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .convertStart(convertStart), .auto_convert_enable(acEnable),
        .auto_period_select(periodSel), .basic_sequencer_on(seqOn),
        .channelInclude(chanInc)
    );

    // Clock, 100 ns period
    initial begin
        sysClk = 1'b0;
        forever #50 sysClk = ~sysClk;
    end

    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic closeOut();
        if (errCount == 0 && nCompared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Address and data offered together, each released once taken
    task automatic writeReg(input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s, input logic [1:0] expResp);
        int n;
        logic awPend, wPend;
        n = 0;
        awPend = 1'b1;
        wPend = 1'b1;
        @(posedge sysClk);
        awAddr <= a;
        wData <= d;
        wStrb <= s;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (n < 100) begin
            @(posedge sysClk);
            n++;
            if (!awPend && !wPend && bValid) begin
                check("write response", {30'h0, bResp}, {30'h0, expResp});
                bReady <= 1'b0;
                n = 200;
            end
            if (awPend && awReady) begin
                awPend = 1'b0;
                awValid <= 1'b0;
            end
            if (wPend && wReady) begin
                wPend = 1'b0;
                wValid <= 1'b0;
            end
        end
        if (n == 100) check("write finished", 32'h0, 32'h1);
    endtask

    task automatic readCheck(input string what, input logic [7:0] a,
            input logic [31:0] exp, input logic [1:0] expResp);
        int n;
        logic arPend;
        n = 0;
        arPend = 1'b1;
        @(posedge sysClk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        while (n < 100) begin
            @(posedge sysClk);
            n++;
            if (!arPend && rValid) begin
                check(what, rData, exp);
                check("read response", {30'h0, rResp}, {30'h0, expResp});
                rReady <= 1'b0;
                n = 200;
            end
            if (arPend && arReady) begin
                arPend = 1'b0;
                arValid <= 1'b0;
            end
        end
        if (n == 100) check("read finished", 32'h0, 32'h1);
    endtask

    // Edges from one convert-start pulse to the next
    task automatic pulseGap(output int g);
        int n;
        n = 0;
        while (!convertStart && n < 20000) begin
            @(posedge sysClk);
            n++;
        end
        @(posedge sysClk);
        check("pulse width", {31'h0, convertStart}, 32'h0);
        g = 1;
        while (!convertStart && g < 20000) begin
            @(posedge sysClk);
            g++;
        end
    endtask

    // Watchdog sized well above the expected run length
    initial begin
        repeat (60000) @(posedge sysClk);
        errCount++;
        closeOut();
    end

    initial begin
        resetN = 1'b0;
        {awValid, wValid, bReady, arValid, rReady} = 5'h00;
        awAddr = 8'h00;
        arAddr = 8'h00;
        wData = 32'h0;
        wStrb = 4'h0;
        errCount = 0;
        nCompared = 0;
        repeat (12) @(posedge sysClk);
        resetN <= 1'b1;
        repeat (2) @(posedge sysClk);
        check("enable pin", {31'h0, acEnable}, 32'h0);
        check("include pins", {16'h0, chanInc}, 32'h1);
        readCheck("autocycle reset", AC_ADDR, 32'h0, OKAY);
        readCheck("mask reset", MASK_ADDR, 32'h1, OKAY);
        readCheck("sequencer reset", SEQ_ADDR, 32'h80, OKAY);
        // Reserved bits must not store anything
        writeReg(AC_ADDR, 32'hFFFF_FFFF, 4'hF, OKAY);
        readCheck("reserved bits", AC_ADDR, 32'h0F, OKAY);
        check("period pins", {29'h0, periodSel}, 32'h7);
        // Every period code, restarted from disabled each time
        for (int c = 0; c < 8; c++) begin
            writeReg(AC_ADDR, 32'h0, 4'hF, OKAY);
            writeReg(AC_ADDR, 32'(c * 2 + 1), 4'hF, OKAY);
            pulseGap(gap);
            check("period", 32'(gap), 32'(usTab[c] * 10));
        end
        writeReg(AC_ADDR, 32'h0, 4'hF, OKAY);
        gap = 0;
        repeat (1000) begin
            @(posedge sysClk);
            if (convertStart) gap++;
        end
        check("pulses when off", 32'(gap), 32'h0);
        // Mask with all lanes, then a single lane
        writeReg(MASK_ADDR, 32'hFFFF_A5C3, 4'hF, OKAY);
        readCheck("mask word", MASK_ADDR, 32'hA5C3, OKAY);
        writeReg(MASK_ADDR, 32'h0000_3C00, 4'h2, OKAY);
        readCheck("mask lane", MASK_ADDR, 32'h3CC3, OKAY);
        repeat (2) @(posedge sysClk);
        check("include pins", {16'h0, chanInc}, 32'h3CC3);
        writeReg(SEQ_ADDR, 32'h0, 4'hF, OKAY);
        repeat (2) @(posedge sysClk);
        check("include when off", {16'h0, chanInc}, 32'h0);
        writeReg(SEQ_ADDR, 32'h80, 4'hF, OKAY);
        repeat (2) @(posedge sysClk);
        check("include when on", {16'h0, chanInc}, 32'h3CC3);
        // Unmapped place is refused and changes nothing
        writeReg(BAD_ADDR, 32'hFFFF_FFFF, 4'hF, SLVERR);
        readCheck("unmapped read", BAD_ADDR, 32'h0, SLVERR);
        // Second reset in mid-run
        writeReg(AC_ADDR, 32'h3, 4'hF, OKAY);
        resetN <= 1'b0;
        repeat (2) @(posedge sysClk);
        resetN <= 1'b1;
        repeat (2) @(posedge sysClk);
        readCheck("mask after reset", MASK_ADDR, 32'h1, OKAY);
        readCheck("autocycle after reset", AC_ADDR, 32'h0, OKAY);
        closeOut();
    end
endmodule

`default_nettype wire

/* File: verilog/autocycle_and_channel_select_config.sv */
// Purpose: Autocycle convert-start timer and channel mask registers
// Assumes: AXI4-Lite master keeps one write and one read in flight
// Notes: Registers sit at byte address four times their index
// What this block does
// - Enabled autocycle fires convert-start at period chosen by bits 3:1.
// - Codes 0 to 3 give 10, 20, 40, 80 microsecond periods.
// - Codes 4 to 7 give 100, 200, 400, 800 microsecond periods.
// - Bit 0 enables autocycle; resets to zero, so off after reset.
// - Bits 7:4 of autocycle control are reserved, read-only, zero.
// - Channel mask bit N includes input N in the standard sequence.
// - Channel mask resets to 0x0001, only input 0 included.
// - Mask acts only while sequencer enable bit 7 is set; resets set.
//
// Implementation choice: register access over AXI4-Lite.
`include "autocycle_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module autocycle_and_channel_select_config #(
    parameter int PERIOD7_CYCLES = `AC_P7_US * `CLK_MHZ
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic convertStart,
    output logic auto_convert_enable,
    output logic [2:0] auto_period_select,
    output logic basic_sequencer_on,
    output logic [15:0] channelInclude
);
    import autocycle_pkg::*;

    localparam int P0 = `AC_P0_US * `CLK_MHZ;
    localparam int P1 = `AC_P1_US * `CLK_MHZ;
    localparam int P2 = `AC_P2_US * `CLK_MHZ;
    localparam int P3 = `AC_P3_US * `CLK_MHZ;
    localparam int P4 = `AC_P4_US * `CLK_MHZ;
    localparam int P5 = `AC_P5_US * `CLK_MHZ;
    localparam int P6 = `AC_P6_US * `CLK_MHZ;

    logic [15:0] sequencer_channel_mask;
    logic [6:0] slotCount;
    logic awHeld, wHeld, arHeld;
    logic [7:0] awAddrQ, arAddrQ;
    logic [31:0] wDataQ;
    logic [3:0] wStrbQ;
    period_t tickCount;
    period_t periodNow;
    reg_sel_t wrSel;

    // Byte address to register; upper index bits must match too
    function automatic reg_sel_t regSelect(input logic [7:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        if ({2'b00, addr[7:2]} == `SEQUENCER_IDX) begin
            sel = SEL_SEQUENCER;
        end else if ({2'b00, addr[7:2]} == `AUTOCYCLE_IDX) begin
            sel = SEL_AUTOCYCLE;
        end else if ({2'b00, addr[7:2]} == `CHAN_MASK_IDX) begin
            sel = SEL_CHAN_MASK;
        end
        return sel;
    endfunction

    // Period code to cycle count
    function automatic period_t periodCycles(input logic [2:0] code);
        period_t n;
        case (code)
            3'h0: n = period_t'(P0);
            3'h1: n = period_t'(P1);
            3'h2: n = period_t'(P2);
            3'h3: n = period_t'(P3);
            3'h4: n = period_t'(P4);
            3'h5: n = period_t'(P5);
            3'h6: n = period_t'(P6);
            default: n = period_t'(PERIOD7_CYCLES);
        endcase
        return n;
    endfunction

    assign periodNow = periodCycles(auto_period_select);
    assign wrSel = regSelect(awAddrQ);

    // Write address channel; one write in flight
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b0;
            awHeld <= 1'b0;
            awAddrQ <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            awHeld <= 1'b1;
            awAddrQ <= s_axi_awaddr;
        end else if (awHeld && wHeld && !s_axi_bvalid) begin
            awHeld <= 1'b0;
        end else if (!awHeld && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    // Write data channel, taken independently of the address
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_wready <= 1'b0;
            wHeld <= 1'b0;
            wDataQ <= 32'h0000_0000;
            wStrbQ <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wHeld <= 1'b1;
            wDataQ <= s_axi_wdata;
            wStrbQ <= s_axi_wstrb;
        end else if (awHeld && wHeld && !s_axi_bvalid) begin
            wHeld <= 1'b0;
        end else if (!wHeld && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    // Write response once both halves are held
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else if (awHeld && wHeld && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wrSel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Register writes; reserved autocycle bits have no storage
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            auto_convert_enable <= `AUTO_ON_RESET;
            auto_period_select <= `AC_PER_RESET;
            basic_sequencer_on <= `SEQ_ON_RESET;
            slotCount <= `SLOT_RESET;
            sequencer_channel_mask <= `MASK_RESET;
        end else if (awHeld && wHeld && !s_axi_bvalid) begin
            case (wrSel)
                SEL_AUTOCYCLE: begin
                    if (wStrbQ[0]) begin
                        auto_convert_enable <= wDataQ[`AUTO_ON_BIT];
                        auto_period_select <=
                            wDataQ[`AC_PER_MSB:`AC_PER_LSB];
                    end
                end
                SEL_SEQUENCER: begin
                    if (wStrbQ[0]) begin
                        basic_sequencer_on <= wDataQ[`SEQ_ON_BIT];
                        slotCount <= wDataQ[`SLOT_MSB:0];
                    end
                end
                SEL_CHAN_MASK: begin
                    if (wStrbQ[0]) begin
                        sequencer_channel_mask[7:0] <= wDataQ[7:0];
                    end
                    if (wStrbQ[1]) begin
                        sequencer_channel_mask[15:8] <= wDataQ[15:8];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Read address channel
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            arHeld <= 1'b0;
            arAddrQ <= 8'h00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            arHeld <= 1'b1;
            arAddrQ <= s_axi_araddr;
        end else if (arHeld) begin
            arHeld <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // Read data; unmapped addresses return zero with an error
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (arHeld) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            case (regSelect(arAddrQ))
                SEL_AUTOCYCLE: s_axi_rdata <= {28'h0000000, auto_period_select,
                    auto_convert_enable};
                SEL_SEQUENCER: s_axi_rdata <= {24'h000000, basic_sequencer_on,
                    slotCount};
                SEL_CHAN_MASK: s_axi_rdata <= {16'h0000,
                    sequencer_channel_mask};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Period timer; >= catches a shortened period at once
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tickCount <= 14'h0000;
            convertStart <= 1'b0;
        end else if (!auto_convert_enable) begin
            tickCount <= 14'h0000;
            convertStart <= 1'b0;
        end else if (tickCount >= periodNow - 14'h0001) begin
            tickCount <= 14'h0000;
            convertStart <= 1'b1;
        end else begin
            tickCount <= tickCount + 14'h0001;
            convertStart <= 1'b0;
        end
    end

    // Mask reaches the sequencer only while it is on
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            channelInclude <= 16'h0000;
        end else begin
            channelInclude <= basic_sequencer_on ?
                sequencer_channel_mask : 16'h0000;
        end
    end

    // Checker helpers: gap between pulses and first cycle after reset
    logic firstCycle, seenPulse;
    period_t gapCount;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            firstCycle <= 1'b1;
            seenPulse <= 1'b0;
            gapCount <= 14'h0000;
        end else begin
            firstCycle <= 1'b0;
            gapCount <= convertStart ? 14'h0001 : gapCount + 14'h0001;
            if (!$stable(auto_period_select) || !auto_convert_enable) begin
                seenPulse <= 1'b0;
            end else if (convertStart) begin
                seenPulse <= 1'b1;
            end
        end
    end

    a_gap_low_codes: assert property (@(posedge sys_clk) disable iff (!reset_n)
        convertStart && seenPulse && $stable(auto_period_select) &&
        !auto_period_select[2] |-> gapCount == periodNow)
        else $error("convert-start gap wrong for low period code");
    a_gap_high_codes: assert property (@(posedge sys_clk) disable iff (!reset_n)
        convertStart && seenPulse && $stable(auto_period_select) &&
        auto_period_select[2] |-> gapCount == periodNow)
        else $error("convert-start gap wrong for high period code");
    a_pulse_one_cycle: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        convertStart |=> !convertStart)
        else $error("convert-start held longer than one cycle");
    a_off_no_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !auto_convert_enable |=> !convertStart)
        else $error("convert-start while autocycle disabled");
    a_ac_reset_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
        firstCycle |-> !auto_convert_enable && auto_period_select == 3'h0 &&
        !convertStart)
        else $error("autocycle control not cleared by reset");
    a_mask_reset: assert property (@(posedge sys_clk) disable iff (!reset_n)
        firstCycle |-> sequencer_channel_mask == `MASK_RESET &&
        basic_sequencer_on)
        else $error("channel mask or sequencer enable reset value wrong");
    a_mask_gating: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !firstCycle |-> channelInclude == ($past(basic_sequencer_on) ?
        $past(sequencer_channel_mask) : 16'h0000))
        else $error("channel include does not follow gated mask");
    a_seq_off_empty: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !basic_sequencer_on [*2] |-> channelInclude == 16'h0000)
        else $error("channels included while sequencer off");
    a_reserved_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
        arHeld && regSelect(arAddrQ) == SEL_AUTOCYCLE |=>
        s_axi_rvalid && s_axi_rdata[31:4] == 28'h0000000)
        else $error("reserved autocycle bits read nonzero");
    a_reserved_wr: assert property (@(posedge sys_clk) disable iff (!reset_n)
        awHeld && wHeld && !s_axi_bvalid && wrSel == SEL_AUTOCYCLE &&
        wStrbQ[0]
        |=> {auto_period_select, auto_convert_enable} == $past(wDataQ[3:0]))
        else $error("autocycle write did not land in low bits only");
    a_bvalid_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
endmodule

`default_nettype wire

/* File: verilog/autocycle_cfg.svh */
// Purpose: Constants for the autocycle and channel select register bank
// Assumes: 10 MHz sys_clk, AXI4-Lite byte addresses of 8 bits
// Notes: Register byte address is four times the register index
`ifndef AUTOCYCLE_CFG_SVH
`define AUTOCYCLE_CFG_SVH

`define CLK_MHZ 10
`define SEQUENCER_IDX 8'h22
`define AUTOCYCLE_IDX 8'h23
`define CHAN_MASK_IDX 8'h24
`define AUTO_ON_BIT 0
`define AC_PER_LSB 1
`define AC_PER_MSB 3
`define SEQ_ON_BIT 7
`define SLOT_MSB 6
`define AUTO_ON_RESET 1'h0
`define AC_PER_RESET 3'h0
`define SEQ_ON_RESET 1'h1
`define SLOT_RESET 7'h00
`define MASK_RESET 16'h0001
`define AC_P0_US 10
`define AC_P1_US 20
`define AC_P2_US 40
`define AC_P3_US 80
`define AC_P4_US 100
`define AC_P5_US 200
`define AC_P6_US 400
`define AC_P7_US 800
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: verilog/autocycle_pkg.sv */
// Purpose: Types shared by the autocycle and channel select bank
// Assumes: Nothing beyond the constants header
// Notes: Register selection is decoded once per bus channel
package autocycle_pkg;
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_SEQUENCER,
        SEL_AUTOCYCLE,
        SEL_CHAN_MASK
    } reg_sel_t;
    typedef logic [13:0] period_t;
endpackage
